// File: rtl/mlu_pkg.sv
/*
  Package for the 48-input majority logic unit: dataway codes, subaddresses,
  register layouts, clock selections and pipeline constants.
  Assumes a single system clock; the dataway is presented synchronously.
*/
package mlu_pkg;

  // ----------------------------------------------------------------
  // dataway
  // ----------------------------------------------------------------
  localparam int DATA_W = 24;
  localparam logic [4:0] FN_READ = 5'h00;
  localparam logic [4:0] FN_WRITE = 5'h10;
  localparam logic [3:0] SUB_MASK_LO = 4'h0;
  localparam logic [3:0] SUB_MASK_HI = 4'h1;
  localparam logic [3:0] SUB_CLK_SEL = 4'h2;
  localparam logic [23:0] MASK_RESET = 24'hFF_FFFF;
  localparam logic [7:0] CLK_SEL_RESET = 8'h00;
  localparam int CLK_SEL_W = 8;

  // ----------------------------------------------------------------
  // inputs and pipeline
  // ----------------------------------------------------------------
  localparam int N_IN = 48;
  localparam int CNT_W = 6;
  localparam int PIPE_STAGES = 7;
  localparam int ONESHOT_CYC = 2;
  localparam int WIDE_STRETCH_CYC = 3;
  localparam int MAX_CLK_MHZ = 40;

  // ----------------------------------------------------------------
  // clock select values
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    MLU_CLK_INT10 = 8'h00,
    MLU_CLK_INT20 = 8'h01,
    MLU_CLK_INT40 = 8'h02,
    MLU_CLK_EXT_B = 8'h03,
    MLU_CLK_EXT_C = 8'h04,
    MLU_CLK_EXT_D = 8'h05
  } mlu_clk_sel_t;

  // one dataway cycle
  typedef struct packed {
    logic strobe;
    logic [4:0] func;
    logic [3:0] sub;
    logic [23:0] wdata;
  } mlu_cmd_t;

  // response to the crate controller
  typedef struct packed {
    logic x;
    logic q;
    logic [23:0] rdata;
  } mlu_rsp_t;

endpackage : mlu_pkg

// File: rtl/mlu_input_shaper.sv
/*
  One input channel: mask, edge detect and one-shot.
  Assumes the input level has already been captured by the top's sampling flop.
*/
`timescale 1ns/1ps
module mlu_input_shaper
  import mlu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // channel
  input wire logic level_i,
  input wire logic enable_i,
  input wire logic wide_mode_i,
  output logic pulse_o
);

  logic prev_q;
  logic [1:0] shot_q;
  logic edge_d;

  // ----------------------------------------------------------------
  // leading edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level_i;
    end
  end

  assign edge_d = level_i & ~prev_q & enable_i;

  // ----------------------------------------------------------------
  // one-shot: two periods, or three in wide-pulse mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shot_q <= 2'h0;
    end else if (edge_d) begin
      shot_q <= wide_mode_i ? 2'(WIDE_STRETCH_CYC) : 2'(ONESHOT_CYC);
    end else if (shot_q != 2'h0) begin
      shot_q <= shot_q - 2'h1;
    end
  end

  assign pulse_o = (shot_q != 2'h0);

endmodule : mlu_input_shaper

// File: rtl/mlu_adder_tree.sv
/*
  Pipelined population count of 48 bits, seven register stages.
  Assumes a new 48-bit vector every clock.
*/
`timescale 1ns/1ps
module mlu_adder_tree
  import mlu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // data
  input wire logic [47:0] bits_i,
  output logic [5:0] count_o
);

  // stage 1: 16 groups of 3 bits -> 2-bit sums
  logic [15:0][1:0] s1_q;
  // stage 2: pairs -> 8 x 3-bit
  logic [7:0][2:0] s2_q;
  // stages 3/4: pairs -> 4 x 4-bit, split low/high
  logic [3:0][1:0] s3lo_q;
  logic [3:0][2:0] s3hi_q;
  logic [3:0][3:0] s4_q;
  // stages 5/6: pairs -> 2 x 5-bit, then 6-bit split
  logic [1:0][4:0] s5_q;
  logic [2:0] s6lo_q;
  // upper sum reaches 12, so it needs four bits
  logic [3:0] s6hi_q;
  logic [5:0] s7_q;

  // ----------------------------------------------------------------
  // adder pipeline; wide adds cut across two stages
  // ----------------------------------------------------------------
  // four-stage 20 MHz variant left out; seven stages kept
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3lo_q <= '0;
      s3hi_q <= '0;
      s4_q <= '0;
      s5_q <= '0;
      s6lo_q <= '0;
      s6hi_q <= '0;
      s7_q <= '0;
    end else begin
      for (int i = 0; i < 16; i++) begin
        s1_q[i] <= 2'(bits_i[3*i]) + 2'(bits_i[3*i+1]) + 2'(bits_i[3*i+2]);
      end
      for (int i = 0; i < 8; i++) begin
        s2_q[i] <= 3'(s1_q[2*i]) + 3'(s1_q[2*i+1]);
      end
      for (int i = 0; i < 4; i++) begin
        s3lo_q[i] <= 2'(s2_q[2*i][0]) + 2'(s2_q[2*i+1][0]);
        s3hi_q[i] <= 3'(s2_q[2*i][2:1]) + 3'(s2_q[2*i+1][2:1]);
        s4_q[i] <= {s3hi_q[i], 1'b0} + 4'(s3lo_q[i]);
      end
      for (int i = 0; i < 2; i++) begin
        s5_q[i] <= 5'(s4_q[2*i]) + 5'(s4_q[2*i+1]);
      end
      s6lo_q <= 3'(s5_q[0][1:0]) + 3'(s5_q[1][1:0]);
      s6hi_q <= 4'(s5_q[0][4:2]) + 4'(s5_q[1][4:2]);
      s7_q <= 6'({s6hi_q, 2'b00}) + 6'(s6lo_q);
    end
  end

  assign count_o = s7_q;

endmodule : mlu_adder_tree

// File: rtl/mlu_top.sv
/*
  48-input majority logic unit: masked, edge-triggered, one-shot shaped
  inputs summed by a pipelined tree; dataway access to mask and clock select.
  Assumes the selected clock arrives already muxed as clk_sys_i and that the
  dataway strobe is one clock wide and synchronous.
*/
// Overview of operation
// - sync each input, two-period one-shot
// - leading edge detect, two-period pulses (50 ns at 40 MHz)
// - seven-stage pipelined adder tree
// - count updates every clock, latency nine
// - 48-bit mask, write F16 read F0
// - accidental coincidence window 1.5 periods
// - real events within one period counted
// - six-bit count of inputs nine clocks back
// - the three-bit and five-bit adds span two stages
// - selectable internal or external clock, 40 MHz max
// - connector A outputs, B C D inputs
// - optional four-stage 20 MHz variant (left out here; only the seven-stage tree is built)
// - optional wide-pulse three-period stretch
// - optional threshold compare trigger output
// - registers via 24-bit dataway
// - subaddress 0 inputs 1-24, 1 inputs 25-48
// - clock select at subaddress 2
`timescale 1ns/1ps
module mlu_top
  import mlu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // front panel inputs, connectors B C D
  input wire logic [47:0] hit_i,
  // options
  input wire logic wide_mode_i,
  input wire logic [5:0] threshold_i,
  // dataway
  input wire mlu_cmd_t cmd_i,
  output mlu_rsp_t rsp_o,
  // connector A outputs
  output logic [5:0] count_o,
  output logic trigger_o,
  output logic [7:0] clk_sel_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [23:0] mask_lo_q;
  logic [23:0] mask_hi_q;
  logic [7:0] clk_sel_q;
  logic is_read;
  logic is_write;
  logic sub_known;

  assign is_read = cmd_i.strobe && (cmd_i.func == FN_READ);
  assign is_write = cmd_i.strobe && (cmd_i.func == FN_WRITE);
  assign sub_known = (cmd_i.sub == SUB_MASK_LO) || (cmd_i.sub == SUB_MASK_HI)
                     || (cmd_i.sub == SUB_CLK_SEL);

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      mask_lo_q <= MASK_RESET;
      mask_hi_q <= MASK_RESET;
    end else if (is_write) begin
      if (cmd_i.sub == SUB_MASK_LO) begin
        mask_lo_q <= cmd_i.wdata;
      end else if (cmd_i.sub == SUB_MASK_HI) begin
        mask_hi_q <= cmd_i.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_q <= CLK_SEL_RESET;
    end else if (is_write && cmd_i.sub == SUB_CLK_SEL) begin
      // values above the last external clock, MLU_CLK_EXT_D, are ignored
      if (cmd_i.wdata[7:0] <= MLU_CLK_EXT_D) begin
        clk_sel_q <= cmd_i.wdata[7:0];
      end
    end
  end

  assign clk_sel_o = clk_sel_q;

  // read response, registered
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      rsp_o <= '0;
    end else begin
      rsp_o.x <= (is_read || is_write) && sub_known;
      rsp_o.q <= (is_read || is_write) && sub_known;
      if (is_read && cmd_i.sub == SUB_MASK_LO) begin
        rsp_o.rdata <= mask_lo_q;
      end else if (is_read && cmd_i.sub == SUB_MASK_HI) begin
        rsp_o.rdata <= mask_hi_q;
      end else if (is_read && cmd_i.sub == SUB_CLK_SEL) begin
        rsp_o.rdata <= {16'h0000, clk_sel_q};
      end else begin
        rsp_o.rdata <= 24'h00_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // input sampling and shaping
  // ----------------------------------------------------------------
  logic [47:0] sample_q;
  logic [47:0] shaped;
  logic [47:0] enable;

  assign enable = {mask_hi_q, mask_lo_q};

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sample_q <= '0;
    end else begin
      sample_q <= hit_i;
    end
  end

  for (genvar g = 0; g < N_IN; g++) begin : g_in
    mlu_input_shaper u_shaper (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n),
      .level_i(sample_q[g]),
      .enable_i(enable[g]),
      .wide_mode_i(wide_mode_i),
      .pulse_o(shaped[g])
    );
  end

  // ----------------------------------------------------------------
  // count and threshold
  // ----------------------------------------------------------------
  logic [5:0] count;

  mlu_adder_tree u_tree (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .bits_i(shaped),
    .count_o(count)
  );

  assign count_o = count;

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      trigger_o <= 1'b0;
    end else begin
      trigger_o <= (count >= threshold_i) && (threshold_i != 6'h00);
    end
  end

endmodule : mlu_top

// File: tb/mlu_ctrl_model.sv
/* Crate controller model: one dataway cycle per call.
   Assumes the answer is registered on the taking edge and read 1 ns after it. */
`timescale 1ns/1ps
module mlu_ctrl_model
  import mlu_pkg::*;
(
  // clock
  input wire logic clk_sys_i,
  // dataway
  output mlu_cmd_t cmd_o,
  input wire mlu_rsp_t rsp_i
);
  // ---
  // cycle
  // ---
  initial cmd_o = '0;
  task automatic cycle(input logic [4:0] f, input logic [3:0] a, input logic [23:0] d,
    output mlu_rsp_t r);
    @(posedge clk_sys_i);
    cmd_o <= {1'b1, f, a, d};
    @(posedge clk_sys_i);
    cmd_o <= {1'b0, ~f, ~a, ~d};
    #1 r = rsp_i;
  endtask : cycle
endmodule : mlu_ctrl_model

// File: tb/mlu_top_monitor.sv
/* Checker on the mlu_top ports.
   Assumes one clock and a one-cycle strobe. */
`timescale 1ns/1ps
module mlu_top_monitor
  import mlu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // watched ports
  input wire logic [47:0] hit_i,
  input wire logic wide_mode_i,
  input wire logic [5:0] threshold_i,
  input wire mlu_cmd_t cmd_i,
  input wire mlu_rsp_t rsp_o,
  input wire logic [5:0] count_o,
  input wire logic trigger_o,
  input wire logic [7:0] clk_sel_o
);
  // ---
  // properties
  // ---
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic [3:0] quiet_q;
  logic ok_w, sel_w;
  assign ok_w = cmd_i.strobe && (cmd_i.func == FN_READ || cmd_i.func == FN_WRITE)
    && cmd_i.sub <= SUB_CLK_SEL;
  assign sel_w = ok_w && cmd_i.func == FN_WRITE && cmd_i.sub == SUB_CLK_SEL
    && cmd_i.wdata[7:0] <= 8'h05;
  // cycles since any input was high
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) quiet_q <= 4'h0;
    else if (hit_i != 48'h0) quiet_q <= 4'h0;
    else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
  end
  AST_ACCEPT: assert property (ok_w |=> rsp_o.x && rsp_o.q)
    else $error("known command not accepted");
  AST_REFUSE: assert property (cmd_i.strobe && !ok_w |=> rsp_o == '0)
    else $error("unknown command answered");
  AST_SEL_SET: assert property (sel_w |=> clk_sel_o == $past(cmd_i.wdata[7:0]))
    else $error("clock select not written");
  AST_SEL_KEEP: assert property (!sel_w |=> $stable(clk_sel_o))
    else $error("clock select changed");
  AST_SEL_READ: assert property (ok_w && cmd_i.func == FN_READ &&
    cmd_i.sub == SUB_CLK_SEL |=> rsp_o.rdata == {16'h0000, $past(clk_sel_o)})
    else $error("clock select read wrong");
  AST_COUNT_MAX: assert property (count_o <= 6'h30)
    else $error("count above input total");
  AST_QUIET: assert property (quiet_q >= 4'hC |-> count_o == 6'h00)
    else $error("count without recent input");
  AST_LATENCY: assert property (quiet_q >= 4'hC && hit_i != 48'h0 |->
    (count_o == 6'h00)[*7])
    else $error("count ahead of pipeline");
  AST_TRIGGER: assert property (trigger_o ==
    ($past(count_o) >= $past(threshold_i) && $past(threshold_i) != 6'h00))
    else $error("trigger disagrees with count");
  COV_SEL: cover property (sel_w);
  COV_TRIG: cover property ($rose(trigger_o));
  COV_FULL: cover property (count_o == 6'h30);
endmodule : mlu_top_monitor

bind mlu_top mlu_top_monitor u_mon (.clk_sys_i, .rst_n_i, .hit_i, .wide_mode_i,
  .threshold_i, .cmd_i, .rsp_o, .count_o, .trigger_o, .clk_sel_o);

// File: tb/tb_majority_logic_unit_48in.sv
/* Bench for mlu_top: register access and count runs.
   Assumes the controller model issues the dataway cycles. */
`timescale 1ns/1ps
module tb_majority_logic_unit_48in;
  import mlu_pkg::*;
  // ---
  // bench
  // ---
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [47:0] hit_i = 48'h0;
  logic wide_mode_i = 1'b0;
  logic [5:0] threshold_i = 6'h00;
  mlu_cmd_t cmd_i;
  mlu_rsp_t rsp_o;
  logic [5:0] count_o;
  logic trigger_o;
  logic [7:0] clk_sel_o;
  int n_errors = 0;
  int check_count = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  mlu_top DUT (.clk_sys_i, .rst_n_i, .hit_i, .wide_mode_i, .threshold_i, .cmd_i,
    .rsp_o, .count_o, .trigger_o, .clk_sel_o);
  mlu_ctrl_model u_ctrl (.clk_sys_i, .cmd_o(cmd_i), .rsp_i(rsp_o));
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("%0d checks, %0d mismatches", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  // a write answers with x and q only
  task automatic rw(input logic [4:0] f, input logic [3:0] a, input logic [23:0] d,
    input logic [25:0] exp);
    mlu_rsp_t r;
    u_ctrl.cycle(f, a, d, r);
    check(f == FN_WRITE ? {r.x, r.q, 24'h0} : r, exp);
  endtask : rw
  // v1 rises at step 0, v2 one step later
  task automatic run(input logic [47:0] v1, v2, input int hold, input logic w,
    input logic [5:0] th, e1, e2);
    logic [5:0] e, ep;
    ep = 6'h00;
    @(posedge clk_sys_i);
    hit_i <= v1;
    wide_mode_i <= w;
    threshold_i <= th;
    for (int j = 1; j <= 14; j++) begin
      @(posedge clk_sys_i);
      if (j == 1) hit_i <= v1 | v2;
      if (j == hold) hit_i <= 48'h0;
      #1;
      e = (j >= 9 && j <= 10 + w ? e1 : 6'h00) + (j >= 10 && j <= 11 + w ? e2 : 6'h00);
      check(count_o, e);
      check(trigger_o, ep >= th && th != 6'h00);
      ep = e;
    end
  endtask : run
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rw(FN_READ, SUB_MASK_LO, 24'h0, {2'b11, MASK_RESET});
    rw(FN_READ, SUB_MASK_HI, 24'h0, {2'b11, MASK_RESET});
    rw(FN_WRITE, SUB_MASK_LO, 24'h00_000F, 26'h300_0000);
    rw(FN_WRITE, SUB_MASK_HI, 24'h80_0000, 26'h300_0000);
    rw(5'h11, SUB_MASK_LO, 24'hFF_FFFF, 26'h0);
    rw(FN_READ, 4'h3, 24'h0, 26'h0);
    rw(FN_READ, SUB_MASK_LO, 24'h0, 26'h300_000F);
    rw(FN_READ, SUB_MASK_HI, 24'h0, 26'h380_0000);
    for (int s = 0; s <= 6; s++) begin
      rw(FN_WRITE, SUB_CLK_SEL, 24'(s), 26'h300_0000);
      check(clk_sel_o, 26'(s > 5 ? 5 : s));
      rw(FN_READ, SUB_CLK_SEL, 24'h0, {2'b11, 24'(s > 5 ? 5 : s)});
    end
    $display("register tests done");
    run({48{1'b1}}, 48'h0, 6, 1'b0, 6'h05, 6'h05, 6'h00);
    run(48'h1, 48'h2, 3, 1'b0, 6'h02, 6'h01, 6'h01);
    rw(FN_WRITE, SUB_MASK_LO, 24'hFF_FFFF, 26'h300_0000);
    rw(FN_WRITE, SUB_MASK_HI, 24'hFF_FFFF, 26'h300_0000);
    run({48{1'b1}}, 48'h0, 2, 1'b1, 6'h30, 6'h30, 6'h00);
    run(48'hFFFF_FFFF_FFFE, 48'h0, 2, 1'b0, 6'h00, 6'h2F, 6'h00);
    $display("count tests done");
    conclude();
  end
  initial begin
    #20000;
    n_errors++;
    conclude();
  end
endmodule : tb_majority_logic_unit_48in
